// ### cgpm_card_model.sv
`timescale 1ns/1ns
module cgpm_card_model (
    input wire clk,
    input wire [5:0] pad_out,
    input wire [5:0] pad_oe_n,
    input wire [5:0] pulldown_en,
    input wire [5:0] drv_en,
    input wire [5:0] drv_val,
    output logic [5:0] pad_in
);
    logic [5:0] last_q = 6'h00;
    always @(posedge clk) begin
        last_q <= pad_in;
    end
    // undriven and not pulled: level toggles every clock
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
            else if (drv_en[i]) pad_in[i] = drv_val[i];
            else if (pulldown_en[i]) pad_in[i] = 1'b0;
            else pad_in[i] = ~last_q[i];
        end
    end
endmodule

// ### cgpm_defines.vh
`ifndef CGPM_DEFINES_VH
`define CGPM_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CGPM_ADDR_W 16
`define CGPM_OFF_PULLDOWN_INHIBIT 16'h1c17
`define CGPM_OFF_BUS_SELECT 16'h1c00
`define CGPM_OFF_FLAG_CTRL 16'h1c01
`define CGPM_OFF_ANALOG_OUT 16'h1c02
`define CGPM_OFF_STATUS 16'h1c03

// ----------------------------------------------------------------
// bus select fields
// ----------------------------------------------------------------
`define CGPM_P0_SEL_LSB 0
`define CGPM_P1_SEL_LSB 2
`define CGPM_SEL_W 2

// port 0 function codes, first listed is zero
`define CGPM_P0_CARD 2'h0
`define CGPM_P0_AUDIO 2'h1
`define CGPM_P0_GPIO 2'h2
`define CGPM_P0_BSER 2'h3
// port 1 function codes
`define CGPM_P1_CARD 2'h0
`define CGPM_P1_MSER 2'h1
`define CGPM_P1_GPIO 2'h2

// ----------------------------------------------------------------
// pulldown inhibit bits: 1 inhibits the pulldown
// ----------------------------------------------------------------
`define CGPM_PD_P0_LSB 0
`define CGPM_PD_P1_LSB 6
`define CGPM_PD_RESET 16'h0fff

// ----------------------------------------------------------------
// flag control fields
// ----------------------------------------------------------------
`define CGPM_FLAG_SCAN_HIZ_BIT 0
`define CGPM_FLAG_STATUS_BIT 13

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CGPM_BUS_SELECT_RESET 16'h0000
`define CGPM_ANALOG_OUT_RESET 16'h0000

`endif

// ### cgpm_flag_ctrl.v
`timescale 1ns/1ns
`include "cgpm_defines.vh"

// external flag output state
module cgpm_flag_ctrl (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire bit_set_instruction,
    input wire bit_clear_instruction,
    input wire status1_wr,
    input wire status1_bit13,
    output reg flag_q
);
    always @(posedge clk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (ce) begin
            if (bit_set_instruction) begin
                flag_q <= 1'b1;
            end else if (bit_clear_instruction) begin
                flag_q <= 1'b0;
            end else if (status1_wr) begin
                flag_q <= status1_bit13;
            end
        end
    end
endmodule

// ### cgpm_port_mux.v
`timescale 1ns/1ns
`include "cgpm_defines.vh"

// six-pad card port mux: slot 0 card, slots 1..3 alternate functions
module cgpm_port_mux #(
    parameter NPAD = 6
) (
    input wire [1:0] sel,
    input wire [NPAD-1:0] f0_out,
    input wire [NPAD-1:0] f0_oe_n,
    input wire [NPAD-1:0] f1_out,
    input wire [NPAD-1:0] f1_oe_n,
    input wire [NPAD-1:0] f2_out,
    input wire [NPAD-1:0] f2_oe_n,
    input wire [NPAD-1:0] f3_out,
    input wire [NPAD-1:0] f3_oe_n,
    input wire [NPAD-1:0] pad_in,
    output reg [NPAD-1:0] pad_out,
    output reg [NPAD-1:0] pad_oe_n,
    output wire [NPAD-1:0] f0_in,
    output wire [NPAD-1:0] f1_in,
    output wire [NPAD-1:0] f2_in,
    output wire [NPAD-1:0] f3_in
);
    always @* begin
        case (sel)
            2'h0: begin
                pad_out = f0_out;
                pad_oe_n = f0_oe_n;
            end
            2'h1: begin
                pad_out = f1_out;
                pad_oe_n = f1_oe_n;
            end
            2'h2: begin
                pad_out = f2_out;
                pad_oe_n = f2_oe_n;
            end
            default: begin
                pad_out = f3_out;
                pad_oe_n = f3_oe_n;
            end
        endcase
    end

    // unselected functions see zeros
    assign f0_in = (sel == 2'h0) ? pad_in : {NPAD{1'b0}};
    assign f1_in = (sel == 2'h1) ? pad_in : {NPAD{1'b0}};
    assign f2_in = (sel == 2'h2) ? pad_in : {NPAD{1'b0}};
    assign f3_in = (sel == 2'h3) ? pad_in : {NPAD{1'b0}};
endmodule

// ### cgpm_props.sv
`timescale 1ns/1ns
module cgpm_props (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire reg_wr,
    input wire bit_set_instruction,
    input wire bit_clear_instruction,
    input wire scan_mode,
    input wire [5:0] port0_pulldown_en_q,
    input wire flag_pad_out_q,
    input wire flag_pad_oe_n_q,
    input wire flag_pullup_en_q,
    input wire [3:0] analog_pad_in,
    input wire [3:0] analog_pad_out_q,
    input wire [3:0] analog_pad_oe_n_q,
    input wire [5:0] adc_chan_q,
    input wire [3:0] card0_dat_in_q,
    input wire [11:0] gpio_in_q,
    input wire [5:0] audio0_in_q,
    input wire [5:0] bser_in_q
);
    reg [3:0] ain_q = 4'h0;
    always @(posedge clk) begin
        ain_q <= analog_pad_in;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    pd_reset_a: assert property ($past(rst) |->
        port0_pulldown_en_q == 6'h00) else $error("pulldown after reset");
    pd_hold_a: assert property (!$past(reg_wr) && !$past(reg_wr, 2)
        |-> $stable(port0_pulldown_en_q)) else $error("pulldown moved");
    flag_set_a: assert property (ce && bit_set_instruction |->
        ##[1:2] (flag_pad_out_q || flag_pad_oe_n_q)) else $error("no set");
    flag_clr_a: assert property (ce && bit_clear_instruction
        && !bit_set_instruction |-> ##[1:2] (!flag_pad_out_q
        || flag_pad_oe_n_q)) else $error("no clear");
    hiz_scan_a: assert property (flag_pad_oe_n_q |->
        $past(scan_mode) || $past(scan_mode, 2)) else $error("hi-z");
    pullup_hiz_a: assert property (
        flag_pullup_en_q == flag_pad_oe_n_q) else $error("pullup");
    adc_map_a: assert property (!$past(rst) && $past(ce) |->
        adc_chan_q == {ain_q[3:1], {3{ain_q[0]}}}) else $error("adc map");
    open_drain_a: assert property (!analog_pad_oe_n_q[0] |->
        !analog_pad_out_q[0]) else $error("pin0 high");
    card_excl_a: assert property (card0_dat_in_q != 4'h0 |->
        gpio_in_q[5:0] == 6'h00 && audio0_in_q == 6'h00
        && bser_in_q == 6'h00) else $error("unselected input");
    cover property (ce && bit_set_instruction);
    cover property (flag_pad_oe_n_q);
    cover property (card0_dat_in_q != 4'h0);
endmodule
bind cgpm_top cgpm_props u_cgpm_props (.*);

// ### cgpm_top.v
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "cgpm_defines.vh"

module cgpm_top (
    input wire clk,
    input wire rst,
    input wire ce,
    // register port
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_q,
    // cpu flag controls
    input wire bit_set_instruction,
    input wire bit_clear_instruction,
    input wire status1_wr,
    input wire [15:0] status1_wdata,
    input wire scan_mode,
    // card controller 0: pads clk, cmd, d0..d3
    input wire card0_clk,
    input wire card0_cmd_out,
    input wire card0_cmd_oe_n,
    input wire [3:0] card0_dat_out,
    input wire [3:0] card0_dat_oe_n,
    output reg card0_cmd_in_q,
    output reg [3:0] card0_dat_in_q,
    // card controller 1
    input wire card1_clk,
    input wire card1_cmd_out,
    input wire card1_cmd_oe_n,
    input wire [3:0] card1_dat_out,
    input wire [3:0] card1_dat_oe_n,
    output reg card1_cmd_in_q,
    output reg [3:0] card1_dat_in_q,
    // alternate peripherals, six pad lanes each
    input wire [5:0] audio0_out,
    input wire [5:0] audio0_oe_n,
    output reg [5:0] audio0_in_q,
    input wire [5:0] bser_out,
    input wire [5:0] bser_oe_n,
    output reg [5:0] bser_in_q,
    input wire [5:0] mser_out,
    input wire [5:0] mser_oe_n,
    output reg [5:0] mser_in_q,
    // general io lanes of port 0 (gpio 0..5) and port 1 (gpio 6..11)
    input wire [11:0] gpio_out,
    input wire [11:0] gpio_oe_n,
    output reg [11:0] gpio_in_q,
    // pads
    input wire [5:0] port0_pad_in,
    output reg [5:0] port0_pad_out_q,
    output reg [5:0] port0_pad_oe_n_q,
    output reg [5:0] port0_pulldown_en_q,
    input wire [5:0] port1_pad_in,
    output reg [5:0] port1_pad_out_q,
    output reg [5:0] port1_pad_oe_n_q,
    output reg [5:0] port1_pulldown_en_q,
    output reg flag_pad_out_q,
    output reg flag_pad_oe_n_q,
    output reg flag_pullup_en_q,
    // analog pins
    input wire [3:0] analog_pad_in,
    output reg [3:0] analog_pad_out_q,
    output reg [3:0] analog_pad_oe_n_q,
    output reg [5:0] adc_chan_q
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [15:0] bus_select_register_q;
    reg [15:0] pad_pulldown_inhibit_1_q;
    reg scan_hiz_q;
    reg [3:0] analog_drive_q;
    reg [3:0] analog_level_q;
    wire flag_q;
    wire [1:0] p0_sel;
    wire [1:0] p1_sel;
    wire [5:0] p0_out;
    wire [5:0] p0_oe_n;
    wire [5:0] p1_out;
    wire [5:0] p1_oe_n;
    wire [5:0] p0_card_in;
    wire [5:0] p0_audio_in;
    wire [5:0] p0_gpio_in;
    wire [5:0] p0_bser_in;
    wire [5:0] p1_card_in;
    wire [5:0] p1_mser_in;
    wire [5:0] p1_gpio_in;
    wire [5:0] p1_spare_in;

    function hit;
        input [15:0] addr;
        input [15:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    assign p0_sel = bus_select_register_q[`CGPM_P0_SEL_LSB +: `CGPM_SEL_W];
    assign p1_sel = bus_select_register_q[`CGPM_P1_SEL_LSB +: `CGPM_SEL_W];

    // ----------------------------------------------------------------
    // bus select register
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            bus_select_register_q <= `CGPM_BUS_SELECT_RESET;
        end else if (ce && reg_wr) begin
            if (hit(reg_addr, `CGPM_OFF_BUS_SELECT)) begin
                bus_select_register_q <= reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // pulldown inhibit register
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            pad_pulldown_inhibit_1_q <= `CGPM_PD_RESET;
        end else if (ce && reg_wr) begin
            if (hit(reg_addr, `CGPM_OFF_PULLDOWN_INHIBIT)) begin
                pad_pulldown_inhibit_1_q <= reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // flag control register
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            scan_hiz_q <= 1'b0;
        end else if (ce && reg_wr) begin
            if (hit(reg_addr, `CGPM_OFF_FLAG_CTRL)) begin
                scan_hiz_q <= reg_wdata[`CGPM_FLAG_SCAN_HIZ_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // analog output register
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            analog_drive_q <= 4'h0;
            analog_level_q <= 4'h0;
        end else if (ce && reg_wr) begin
            if (hit(reg_addr, `CGPM_OFF_ANALOG_OUT)) begin
                analog_drive_q <= reg_wdata[3:0];
                analog_level_q <= reg_wdata[7:4];
            end
        end
    end

    // ----------------------------------------------------------------
    // register reads, one cycle later
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata_q <= 16'h0000;
        end else if (ce) begin
            reg_rdata_q <= 16'h0000;
            if (reg_rd) begin
                if (hit(reg_addr, `CGPM_OFF_BUS_SELECT)) begin
                    reg_rdata_q <= bus_select_register_q;
                end else if (hit(reg_addr, `CGPM_OFF_PULLDOWN_INHIBIT)) begin
                    reg_rdata_q <= pad_pulldown_inhibit_1_q;
                end else if (hit(reg_addr, `CGPM_OFF_FLAG_CTRL)) begin
                    reg_rdata_q <= {15'h0000, scan_hiz_q};
                end else if (hit(reg_addr, `CGPM_OFF_ANALOG_OUT)) begin
                    reg_rdata_q <= {8'h00, analog_level_q, analog_drive_q};
                end else if (hit(reg_addr, `CGPM_OFF_STATUS)) begin
                    reg_rdata_q <= {2'b00, flag_q, 9'h000, analog_pad_in};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // pad muxes
    // ----------------------------------------------------------------
    // port 0 order: card, audio, gpio, buffered serial
    cgpm_port_mux #(.NPAD(6)) u_port0 (
        .sel(p0_sel),
        .f0_out({card0_dat_out, card0_cmd_out, card0_clk}),
        .f0_oe_n({card0_dat_oe_n, card0_cmd_oe_n, 1'b0}),
        .f1_out(audio0_out),
        .f1_oe_n(audio0_oe_n),
        .f2_out(gpio_out[5:0]),
        .f2_oe_n(gpio_oe_n[5:0]),
        .f3_out(bser_out),
        .f3_oe_n(bser_oe_n),
        .pad_in(port0_pad_in),
        .pad_out(p0_out),
        .pad_oe_n(p0_oe_n),
        .f0_in(p0_card_in),
        .f1_in(p0_audio_in),
        .f2_in(p0_gpio_in),
        .f3_in(p0_bser_in)
    );

    // port 1 order: card, multichannel serial, gpio
    cgpm_port_mux #(.NPAD(6)) u_port1 (
        .sel(p1_sel),
        .f0_out({card1_dat_out, card1_cmd_out, card1_clk}),
        .f0_oe_n({card1_dat_oe_n, card1_cmd_oe_n, 1'b0}),
        .f1_out(mser_out),
        .f1_oe_n(mser_oe_n),
        .f2_out(gpio_out[11:6]),
        .f2_oe_n(gpio_oe_n[11:6]),
        .f3_out(6'h00),
        .f3_oe_n(6'h3f),
        .pad_in(port1_pad_in),
        .pad_out(p1_out),
        .pad_oe_n(p1_oe_n),
        .f0_in(p1_card_in),
        .f1_in(p1_mser_in),
        .f2_in(p1_gpio_in),
        .f3_in(p1_spare_in)
    );

    cgpm_flag_ctrl u_flag (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .bit_set_instruction(bit_set_instruction),
        .bit_clear_instruction(bit_clear_instruction),
        .status1_wr(status1_wr),
        .status1_bit13(status1_wdata[`CGPM_FLAG_STATUS_BIT]),
        .flag_q(flag_q)
    );

    // ----------------------------------------------------------------
    // pad drive
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            port0_pad_out_q <= 6'h00;
            port0_pad_oe_n_q <= 6'h3f;
            port1_pad_out_q <= 6'h00;
            port1_pad_oe_n_q <= 6'h3f;
        end else if (ce) begin
            port0_pad_out_q <= p0_out;
            port0_pad_oe_n_q <= p0_oe_n;
            port1_pad_out_q <= p1_out;
            port1_pad_oe_n_q <= p1_oe_n;
        end
    end

    // ----------------------------------------------------------------
    // pulldown control
    // ----------------------------------------------------------------
    // a set inhibit bit keeps that pad's pulldown off
    function [5:0] pull_enable;
        input [5:0] inhibit;
        begin
            pull_enable = ~inhibit;
        end
    endfunction

    always @(posedge clk) begin
        if (rst) begin
            port0_pulldown_en_q <= 6'h00;
            port1_pulldown_en_q <= 6'h00;
        end else if (ce) begin
            port0_pulldown_en_q <= pull_enable(
                pad_pulldown_inhibit_1_q[`CGPM_PD_P0_LSB +: 6]);
            port1_pulldown_en_q <= pull_enable(
                pad_pulldown_inhibit_1_q[`CGPM_PD_P1_LSB +: 6]);
        end
    end

    // ----------------------------------------------------------------
    // peripheral inputs, zero while the function is not selected
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            card0_cmd_in_q <= 1'b0;
            card0_dat_in_q <= 4'h0;
            card1_cmd_in_q <= 1'b0;
            card1_dat_in_q <= 4'h0;
            audio0_in_q <= 6'h00;
            bser_in_q <= 6'h00;
            mser_in_q <= 6'h00;
            gpio_in_q <= 12'h000;
        end else if (ce) begin
            card0_cmd_in_q <= p0_card_in[1];
            card0_dat_in_q <= p0_card_in[5:2];
            card1_cmd_in_q <= p1_card_in[1];
            card1_dat_in_q <= p1_card_in[5:2];
            audio0_in_q <= p0_audio_in;
            bser_in_q <= p0_bser_in;
            mser_in_q <= p1_mser_in;
            gpio_in_q <= {p1_gpio_in, p0_gpio_in};
        end
    end

    // ----------------------------------------------------------------
    // flag pad
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            flag_pad_out_q <= 1'b0;
            flag_pad_oe_n_q <= 1'b0;
            flag_pullup_en_q <= 1'b0;
        end else if (ce) begin
            flag_pad_out_q <= flag_q;
            // released only when scan mode and the request bit are both set
            flag_pad_oe_n_q <= scan_mode & scan_hiz_q;
            flag_pullup_en_q <= scan_mode & scan_hiz_q;
        end
    end

    // ----------------------------------------------------------------
    // analog pins
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            analog_pad_out_q <= 4'h0;
            analog_pad_oe_n_q <= 4'hf;
            adc_chan_q <= 6'h00;
        end else if (ce) begin
            // pin 0 open drain: only ever pulls low
            analog_pad_out_q <= {analog_level_q[3:1], 1'b0};
            analog_pad_oe_n_q <= {~analog_drive_q[3:1],
                ~(analog_drive_q[0] & ~analog_level_q[0])};
            adc_chan_q[2:0] <= {3{analog_pad_in[0]}};
            adc_chan_q[5:3] <= analog_pad_in[3:1];
        end
    end
endmodule

// ### tb.sv
`timescale 1ns/1ns
module tb;
    logic clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, rd_seen = 0;
    logic bit_set_instruction = 0, bit_clear_instruction = 0;
    logic status1_wr = 0, scan_mode = 0, card0_clk = 0, card1_clk = 0;
    logic card0_cmd_out = 0, card0_cmd_oe_n = 1;
    logic card1_cmd_out = 0, card1_cmd_oe_n = 1;
    logic [15:0] reg_addr = '0, reg_wdata = '0, status1_wdata = '0, r;
    logic [3:0] card0_dat_out = '0, card0_dat_oe_n = 4'hf, analog_pad_in = '0;
    logic [3:0] card1_dat_out = '0, card1_dat_oe_n = 4'hf;
    logic [5:0] audio0_out = '0, audio0_oe_n = 6'h3f, bser_out = '0;
    logic [5:0] bser_oe_n = 6'h3f, mser_out = '0, mser_oe_n = 6'h3f;
    logic [5:0] drv_en = '0, drv_val = '0, e0, e1;
    logic [11:0] gpio_out = '0, gpio_oe_n = 12'hfff;
    logic [19:0] n;
    wire [15:0] reg_rdata_q;
    wire card0_cmd_in_q, card1_cmd_in_q, flag_pad_out_q, flag_pad_oe_n_q;
    wire flag_pullup_en_q;
    wire [3:0] card0_dat_in_q, card1_dat_in_q;
    wire [3:0] analog_pad_out_q, analog_pad_oe_n_q;
    wire [5:0] audio0_in_q, bser_in_q, mser_in_q, adc_chan_q;
    wire [5:0] port0_pad_in, port0_pad_out_q, port0_pad_oe_n_q;
    wire [5:0] port1_pad_in, port1_pad_out_q, port1_pad_oe_n_q;
    wire [5:0] port0_pulldown_en_q, port1_pulldown_en_q;
    wire [11:0] gpio_in_q;
    wire [15:0] view [0:8];
    logic [15:0] rq [$];
    logic [19:0] pq [$];
    int failures = 0, checks_done = 0;
    string nm [0:8] = '{"rdata", "port0", "port1", "pulldown", "flag",
        "gpio_in", "alt_in", "card_in", "analog"};
    assign view[0] = reg_rdata_q;
    assign view[1] = {4'h0, port0_pad_oe_n_q, port0_pad_out_q};
    assign view[2] = {4'h0, port1_pad_oe_n_q, port1_pad_out_q};
    assign view[3] = {4'h0, port1_pulldown_en_q, port0_pulldown_en_q};
    assign view[4] = {13'h0, flag_pullup_en_q, flag_pad_oe_n_q,
        flag_pad_out_q};
    assign view[5] = {4'h0, gpio_in_q};
    assign view[6] = {4'h0, audio0_in_q, bser_in_q};
    assign view[7] = {card1_cmd_in_q, card1_dat_in_q, card0_cmd_in_q,
        card0_dat_in_q, mser_in_q};
    assign view[8] = {2'h0, adc_chan_q, analog_pad_oe_n_q, analog_pad_out_q};
    always #2 clk = ~clk;
    cgpm_top u_cgpm_top (.*);
    cgpm_card_model u_cgpm_card_model_0 (.clk(clk), .pad_out(port0_pad_out_q),
        .pad_oe_n(port0_pad_oe_n_q), .pulldown_en(port0_pulldown_en_q),
        .drv_en(drv_en), .drv_val(drv_val), .pad_in(port0_pad_in));
    cgpm_card_model u_cgpm_card_model_1 (.clk(clk), .pad_out(port1_pad_out_q),
        .pad_oe_n(port1_pad_oe_n_q), .pulldown_en(port1_pulldown_en_q),
        .drv_en(drv_en), .drv_val(drv_val), .pad_in(port1_pad_in));
    // ----
    // checking
    // ----
    task automatic cmp(input int k, input logic [15:0] e,
        input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm[k], e, g);
        end
    endtask
    task automatic wrap_up;
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) rd_seen <= reg_rd & ce;
    always @(negedge clk) begin
        if (rd_seen) cmp(0, rq.pop_front(), view[0]);
        while (pq.size() > 0) begin
            n = pq.pop_front();
            cmp(n[19:16], n[15:0], view[n[19:16]]);
        end
    end
    initial begin
        #100000;
        failures++;
        wrap_up;
    end
    // ----
    // driving
    // ----
    task automatic step(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic pr(input logic [3:0] k, input logic [15:0] e);
        step(1);
        pq.push_back({k, e});
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        step(1);
        reg_wr <= 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        step(1);
        reg_rd <= 1'b0;
        rq.push_back(e);
        step(1);
    endtask
    task automatic fl(input logic [2:0] v);
        {bit_set_instruction, bit_clear_instruction, status1_wr} <= v;
        step(1);
        {bit_set_instruction, bit_clear_instruction, status1_wr} <= 3'h0;
        step(1);
    endtask
    initial begin
        void'($urandom(32'hb606_c0f9));
        step(3);
        rst <= 1'b0;
        step(1);
        rd(16'h1c17, 16'h0fff);
        rd(16'h1c00, 16'h0000);
        rd(16'h1c10, 16'h0000);
        pr(3, 16'h0000);
        pr(4, 16'h0000);
        r = 16'($urandom) & 16'h0fff;
        wr(16'h1c17, r);
        pr(3, {4'h0, ~r[11:0]});
        rd(16'h1c17, r);
        r = 16'($urandom);
        drv_en <= 6'h3e;
        drv_val <= r[5:0];
        pr(1, 16'h0f80);
        pr(7, {r[1], r[5:2], r[1], r[5:2], 6'h00});
        drv_en <= 6'h00;
        for (int s = 0; s < 12; s++) begin
            {card0_clk, card0_cmd_out, card0_dat_out, card1_clk,
                card1_cmd_out, card1_dat_out} <= 12'($urandom);
            {audio0_out, bser_out, mser_out} <= 18'($urandom);
            gpio_out <= 12'($urandom);
            {card0_cmd_oe_n, card0_dat_oe_n, card1_cmd_oe_n} <= '0;
            {card1_dat_oe_n, audio0_oe_n, bser_oe_n, mser_oe_n} <= '0;
            gpio_oe_n <= '0;
            wr(16'h1c00, {12'h000, 2'(s / 4), 2'(s % 4)});
            e0 = s % 4 == 0 ? {card0_dat_out, card0_cmd_out, card0_clk} :
                s % 4 == 1 ? audio0_out : s % 4 == 2 ? gpio_out[5:0] : bser_out;
            e1 = s / 4 == 0 ? {card1_dat_out, card1_cmd_out, card1_clk} :
                s / 4 == 1 ? mser_out : gpio_out[11:6];
            pr(1, {10'h000, e0});
            pr(2, {10'h000, e1});
            pr(5, {4'h0, s / 4 == 2 ? gpio_out[11:6] : 6'h00,
                s % 4 == 2 ? gpio_out[5:0] : 6'h00});
            pr(6, {4'h0, s % 4 == 1 ? audio0_out : 6'h00,
                s % 4 == 3 ? bser_out : 6'h00});
        end
        ce <= 1'b0;
        wr(16'h1c00, 16'h0000);
        ce <= 1'b1;
        rd(16'h1c00, 16'h000b);
        status1_wdata <= 16'($urandom) & 16'hdfff;
        fl(3'h4);
        pr(4, 16'h0001);
        fl(3'h2);
        pr(4, 16'h0000);
        fl(3'h4);
        fl(3'h1);
        pr(4, 16'h0000);
        wr(16'h1c01, 16'h0001);
        pr(4, 16'h0000);
        scan_mode <= 1'b1;
        step(1);
        pr(4, 16'h0006);
        scan_mode <= 1'b0;
        step(1);
        pr(4, 16'h0000);
        r = 16'($urandom);
        analog_pad_in <= r[3:0];
        wr(16'h1c02, 16'h00ef);
        pr(8, {2'h0, r[3:1], {3{r[0]}}, 8'h0e});
        step(2);
        wrap_up;
    end
endmodule
